// *** rtl/mvp_pkg.sv ***
// Shared constants, encodings and carrier types of the valve positioner
package mvp_pkg;
	// Timing: the base tick is the 0.1 s unit of travel time
	localparam int unsigned MVP_CLK_HZ          = 20_000_000;
	localparam int unsigned MVP_TICK_MS         = 100;
	localparam int unsigned MVP_TICK_CYCLES     = MVP_CLK_HZ / 1000 * MVP_TICK_MS;
	localparam int unsigned MVP_CAL_TIMEOUT_S   = 360;
	localparam logic [11:0] MVP_CAL_TIMEOUT_TKS = 12'(MVP_CAL_TIMEOUT_S * 1000 / MVP_TICK_MS);
	localparam logic [11:0] MVP_STALL_TICKS     = 12'h00a;
	localparam logic [15:0] MVP_STALL_DELTA     = 16'h0004;
	// Percent values in 0.1 % units
	localparam logic signed [11:0] MVP_PCT_FULL  = 12'sh3e8;
	localparam logic signed [11:0] MVP_PCT_OVER  = 12'sh41a;
	localparam logic signed [11:0] MVP_PCT_UNDER = -12'sh032;
	localparam logic [12:0] MVP_STEP_SCALE = 13'h03e8;
	// Setting ranges and reset values
	localparam logic [15:0] MVP_DB_MIN     = 16'h0005;
	localparam logic [15:0] MVP_DB_MAX     = 16'h03e8;
	localparam logic [15:0] MVP_DB_RST     = 16'h0064;
	localparam logic [11:0] MVP_TR_MIN     = 12'h032;
	localparam logic [11:0] MVP_TR_MAX     = 12'hbb8;
	localparam logic [11:0] MVP_TR_RST     = 12'h12c;
	localparam logic [15:0] MVP_CLOSED_RST = 16'h0000;
	localparam logic [15:0] MVP_OPEN_RST   = 16'hffff;
	localparam logic [15:0] MVP_SPAN_MIN   = 16'h0100;
	// Register byte addresses
	localparam logic [7:0] MVP_A_CTRL     = 8'h00;
	localparam logic [7:0] MVP_A_DEADBAND = 8'h04;
	localparam logic [7:0] MVP_A_TRAVEL   = 8'h08;
	localparam logic [7:0] MVP_A_CLOSED   = 8'h0c;
	localparam logic [7:0] MVP_A_OPEN     = 8'h10;
	localparam logic [7:0] MVP_A_MV       = 8'h14;
	localparam logic [7:0] MVP_A_STATUS   = 8'h18;
	localparam logic [7:0] MVP_A_POSITION = 8'h1c;
	localparam logic [7:0] MVP_A_IRQ_STAT = 8'h20;
	localparam logic [7:0] MVP_A_IRQ_MASK = 8'h24;
	localparam logic [7:0] MVP_A_RAW      = 8'h28;
	// Control register fields and interrupt bits
	localparam int unsigned MVP_CTRL_MODE_LSB = 0;
	localparam int unsigned MVP_CTRL_CAL_LSB  = 4;
	localparam int unsigned MVP_IRQ_CAL_DONE  = 0;
	localparam int unsigned MVP_IRQ_CAL_ERR   = 1;
	localparam int unsigned MVP_IRQ_FAULT     = 2;
	localparam int unsigned MVP_IRQ_W         = 3;

	typedef enum logic [1:0] {
		MVP_FEEDBACK_MODE = 2'b00,
		MVP_FB_EST_MODE   = 2'b01,
		MVP_EST_ONE_MODE  = 2'b10,
		MVP_EST_TWO_MODE  = 2'b11
	} mvp_mode_t;

	typedef enum logic [1:0] {
		MVP_CAL_OFF    = 2'b00,
		MVP_CAL_CLOSED = 2'b01,
		MVP_CAL_OPEN   = 2'b10,
		MVP_CAL_AUTO   = 2'b11
	} mvp_cal_cmd_t;

	typedef enum logic [1:0] {
		MVP_CS_IDLE  = 2'b00,
		MVP_CS_CLOSE = 2'b01,
		MVP_CS_OPEN  = 2'b10,
		MVP_CS_ERR   = 2'b11
	} mvp_cal_state_t;

	// Status register layout, bit 6 (cal_err) first
	typedef struct packed {
		logic cal_err;
		logic cal_busy;
		logic under;
		logic over;
		logic est;
		logic close;
		logic open;
	} mvp_stat_t;
endpackage

// *** rtl/mvp_div.sv ***
// Serial restoring divider used for the feedback-to-percent scaling
module mvp_div import mvp_pkg::*; #(
	parameter int unsigned NUM_W = 26,
	parameter int unsigned DEN_W = 16
) (
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	input  wire logic             start_i,
	input  wire logic [NUM_W-1:0] num_i,
	input  wire logic [DEN_W-1:0] den_i,
	output logic                  busy_o,
	output logic                  done_o,
	output logic [NUM_W-1:0]      quo_o
);
	logic [DEN_W:0]   rem, next_rem, shifted, trial;
	logic [NUM_W-1:0] quo, next_quo;
	logic [DEN_W-1:0] den, next_den;
	logic [5:0]       cnt, next_cnt;
	logic             done, next_done;

	// One quotient bit per cycle; a zero divisor yields all ones only when num_i fits in DEN_W bits
	always_comb begin
		next_rem  = rem;
		next_quo  = quo;
		next_den  = den;
		next_cnt  = cnt;
		next_done = 1'b0;
		shifted   = {rem[DEN_W-1:0], quo[NUM_W-1]};
		trial     = shifted - {1'b0, den};
		if (cnt != 6'h00) begin
			next_cnt = cnt - 6'h01;
			next_rem = trial[DEN_W] ? shifted : trial;
			next_quo = {quo[NUM_W-2:0], ~trial[DEN_W]};
			next_done = (cnt == 6'h01);
		end else if (start_i) begin
			next_rem = '0;
			next_quo = num_i;
			next_den = den_i;
			next_cnt = 6'(NUM_W);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rem  <= '0;
			quo  <= '0;
			den  <= '0;
			cnt  <= 6'h00;
			done <= 1'b0;
		end else begin
			rem  <= next_rem;
			quo  <= next_quo;
			den  <= next_den;
			cnt  <= next_cnt;
			done <= next_done;
		end
	end

	assign busy_o = (cnt != 6'h00);
	assign done_o = done;
	assign quo_o  = quo;
endmodule

// *** rtl/mvp_positioner.sv ***
// Motorized valve positioner: open/close drive, estimation, calibration, Wishbone registers
//
// The implementer's own choices: the placing of the registers and the Wishbone interface to the registers.
module mvp_positioner import mvp_pkg::*; #(
	parameter int unsigned TICK_CYCLES = MVP_TICK_CYCLES
) (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic [7:0]  adr_i,
	input  wire logic [31:0] dat_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic        we_i,
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	output logic [31:0]      dat_o,
	output logic             ack_o,
	input  wire logic [15:0] fb_raw_i,
	input  wire logic        fb_neg_fault_i,
	input  wire logic        fb_pos_fault_i,
	output logic             valve_open_o,
	output logic             valve_close_o,
	output logic             irq_o
);
	logic [15:0] raw_s1, raw_s2;
	logic [1:0]  flt_s1, flt_s2;
	logic [31:0] tick_cnt, next_tick_cnt;
	logic        tick;
	mvp_mode_t   mode, next_mode;
	logic [15:0] dead_band, next_dead_band, cal_closed, next_cal_closed, cal_open, next_cal_open;
	logic [11:0] travel, next_travel;
	logic signed [15:0] mv, next_mv;
	logic [MVP_IRQ_W-1:0] irq_stat, next_irq_stat, irq_mask, next_irq_mask, irq_ev;
	logic [31:0] rdata, next_rdata;
	logic        ack, next_ack, wr_stb, wr_cal;
	mvp_cal_cmd_t   wcmd;
	mvp_mode_t      wmode;
	mvp_cal_state_t cal_state, next_cal_state;
	logic [11:0] cal_cnt, next_cal_cnt, stall, next_stall, trav_meas, next_trav_meas;
	logic [15:0] snap, next_snap, tmp_closed, next_tmp_closed, diff;
	logic        cal_store, cal_done_ev, cal_err_ev;
	logic        over, under, fault, fault_q, estimating;
	logic        div_busy, div_done;
	logic [25:0] div_quo;
	logic signed [11:0] fb_pct, next_fb_pct, fb_val, ctl_pos, rep_pos;
	logic [10:0] est_pos, next_est_pos;
	logic [12:0] frac, next_frac;
	logic [11:0] start_cnt, next_start_cnt;
	logic        start_done, next_start_done, open_q, next_open, close_q, next_close;
	logic signed [16:0] err, on_th, off_th;
	mvp_stat_t   stat;

	// Pins come from outside the clock domain; two flops before use
	always_ff @(posedge clk_i) begin
		raw_s1 <= fb_raw_i;
		raw_s2 <= raw_s1;
		flt_s1 <= {fb_pos_fault_i, fb_neg_fault_i};
		flt_s2 <= flt_s1;
	end

	// 0.1 s tick divider
	always_comb begin
		tick          = (tick_cnt == 32'(TICK_CYCLES - 1));
		next_tick_cnt = tick ? 32'h0 : tick_cnt + 32'h1;
	end

	//////////////////////////////////////////////////////////////////////
	// fault substitution; both lines shorted counts as under-range
	assign under      = flt_s2[1];
	assign over       = flt_s2[0] & ~flt_s2[1];
	assign fault      = flt_s2[0] | flt_s2[1];
	assign fb_val     = under ? MVP_PCT_UNDER : (over ? MVP_PCT_OVER : fb_pct);
	// fallback mode estimates only while the feedback is abnormal
	// estimation-only modes never look at the feedback
	assign estimating = mode[1] | ((mode == MVP_FB_EST_MODE) & fault);
	// reported position follows whatever the loop is using
	assign ctl_pos    = estimating ? 12'(signed'({1'b0, est_pos})) : fb_val;
	assign rep_pos    = ctl_pos;

	// linear scaling, recomputed continuously by the serial divider
	mvp_div #(.NUM_W(26), .DEN_W(16)) u_div (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.start_i (~div_busy),
		.num_i   (26'({10'h000, raw_s2 - cal_closed} * 26'd1000)),
		.den_i   (cal_open - cal_closed),
		.busy_o  (div_busy),
		.done_o  (div_done),
		.quo_o   (div_quo)
	);

	// Clamp at the end points so an out-of-span reading never wraps
	always_comb begin
		next_fb_pct = fb_pct;
		if (div_done) begin
			if (raw_s2 <= cal_closed || cal_open <= cal_closed)
				next_fb_pct = 12'sh000;
			else if (raw_s2 >= cal_open)
				next_fb_pct = MVP_PCT_FULL;
			else
				next_fb_pct = 12'(div_quo[10:0]);
		end
	end

	//////////////////////////////////////////////////////////////////////
	// Calibration sequencer
	assign wmode = mvp_mode_t'(dat_i[MVP_CTRL_MODE_LSB +: 2]);
	assign wcmd  = mvp_cal_cmd_t'(dat_i[MVP_CTRL_CAL_LSB +: 2]);
	assign diff  = (raw_s2 > snap) ? raw_s2 - snap : snap - raw_s2;

	// End of stroke is taken as the reading standing still for one second
	always_comb begin
		next_cal_state  = cal_state;
		next_cal_cnt    = cal_cnt;
		next_stall      = stall;
		next_snap       = snap;
		next_tmp_closed = tmp_closed;
		next_trav_meas  = trav_meas;
		cal_store       = 1'b0;
		cal_done_ev     = 1'b0;
		cal_err_ev      = 1'b0;
		if (wr_cal) begin
			// estimation-only modes leave the command at off
			if (wcmd == MVP_CAL_AUTO && !wmode[1]) begin
				next_cal_state = MVP_CS_CLOSE;
				next_cal_cnt   = 12'h000;
				next_stall     = 12'h000;
				next_snap      = raw_s2;
			end else if (wcmd == MVP_CAL_OFF) begin
				next_cal_state = MVP_CS_IDLE;
			end
		end else if (cal_state == MVP_CS_CLOSE || cal_state == MVP_CS_OPEN) begin
			// burnout or timeout aborts without storing
			if (fault || (tick && cal_cnt == MVP_CAL_TIMEOUT_TKS - 12'h001)) begin
				next_cal_state = MVP_CS_ERR;
				cal_err_ev     = 1'b1;
			end else if (tick) begin
				next_cal_cnt   = cal_cnt + 12'h001;
				next_trav_meas = trav_meas + 12'h001;
				next_snap      = raw_s2;
				next_stall     = (diff < MVP_STALL_DELTA) ? stall + 12'h001 : 12'h000;
				// close phase first, then open phase
				if (stall == MVP_STALL_TICKS - 12'h001 && diff < MVP_STALL_DELTA) begin
					if (cal_state == MVP_CS_CLOSE) begin
						next_tmp_closed = raw_s2;
						next_cal_state  = MVP_CS_OPEN;
						next_stall      = 12'h000;
						next_trav_meas  = 12'h000;
					end else if (tmp_closed > raw_s2 || raw_s2 - tmp_closed < MVP_SPAN_MIN
						|| trav_meas + 12'h001 - MVP_STALL_TICKS < MVP_TR_MIN
						|| trav_meas + 12'h001 - MVP_STALL_TICKS > MVP_TR_MAX) begin
						next_cal_state = MVP_CS_ERR;
						cal_err_ev     = 1'b1;
					end else begin
						next_cal_state = MVP_CS_IDLE;
						cal_store      = 1'b1;
						cal_done_ev    = 1'b1;
					end
				end
			end
		end
	end

	//////////////////////////////////////////////////////////////////////
	// Estimation: startup close, tracking, and travel-time integration
	always_comb begin
		next_est_pos    = est_pos;
		next_frac       = frac;
		next_start_cnt  = start_cnt;
		next_start_done = start_done;
		// first entry into mode two after reset closes for one stroke
		if (mode == MVP_EST_TWO_MODE && !start_done) begin
			if (tick)
				next_start_cnt = start_cnt + 12'h001;
			if (start_cnt >= travel) begin
				next_start_done = 1'b1;
				next_est_pos    = 11'h000;
				next_frac       = 13'h0000;
			end
		end else if (!estimating) begin
			// Track feedback so a fallback switch starts from the last good value
			next_est_pos = (fb_pct < 12'sh000) ? 11'h000 : 11'(fb_pct);
			next_frac    = 13'h0000;
		end else if (!open_q && !close_q) begin
			next_frac = 13'h0000;
		// each tick adds full scale; each travel-time worth is one step
		end else if (tick) begin
			next_frac = frac + MVP_STEP_SCALE;
		end else if (frac >= {1'b0, travel}) begin
			next_frac = frac - {1'b0, travel};
			if (open_q && est_pos < 11'(MVP_PCT_FULL))
				next_est_pos = est_pos + 11'h001;
			else if (close_q && est_pos != 11'h000)
				next_est_pos = est_pos - 11'h001;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// Drive outputs
	// release point sits a quarter dead band inside the switch point
	assign err    = 17'(mv) - 17'(ctl_pos);
	assign on_th  = 17'({1'b0, dead_band[15:1]});
	assign off_th = on_th - 17'({2'b00, dead_band[15:2]});

	always_comb begin
		next_open  = 1'b0;
		next_close = 1'b0;
		if (cal_state == MVP_CS_CLOSE) begin
			next_close = 1'b1;
		end else if (cal_state == MVP_CS_OPEN) begin
			next_open = 1'b1;
		end else if (mode == MVP_EST_TWO_MODE && !start_done) begin
			next_close = 1'b1;
		end else if (estimating && mv <= 16'sh0000) begin
			next_close = 1'b1;
		end else if (estimating && mv >= 16'(MVP_PCT_FULL)) begin
			next_open = 1'b1;
		end else begin
			// drive toward the target; quiet inside the dead band
			next_open  = open_q ? (err > off_th) : (err > on_th);
			next_close = close_q ? (err < -off_th) : (err < -on_th);
		end
	end

	//////////////////////////////////////////////////////////////////////
	// Wishbone slave; unmapped reads return zero, unmapped writes are dropped
	assign wr_stb = cyc_i & stb_i & we_i & ~ack;
	assign wr_cal = wr_stb & (adr_i == MVP_A_CTRL) & sel_i[0];
	assign stat   = '{cal_err: (cal_state == MVP_CS_ERR), cal_busy: cal_state[0] ^ cal_state[1],
		under: under, over: over, est: estimating, close: close_q, open: open_q};
	assign irq_ev = {fault & ~fault_q, cal_err_ev, cal_done_ev};

	always_comb begin
		next_ack        = cyc_i & stb_i & ~ack;
		next_rdata      = rdata;
		next_mode       = mode;
		next_dead_band  = dead_band;
		next_travel     = travel;
		next_cal_closed = cal_closed;
		next_cal_open   = cal_open;
		next_mv         = mv;
		next_irq_mask   = irq_mask;
		// Set wins over a simultaneous write-one clear
		next_irq_stat   = irq_stat | irq_ev;
		if (cyc_i && stb_i && !ack && !we_i) begin
			case (adr_i)
				// command reads back as auto while the sequencer runs
				MVP_A_CTRL:     next_rdata = 32'({stat.cal_busy, stat.cal_busy, 2'b00, mode});
				MVP_A_DEADBAND: next_rdata = {16'h0000, dead_band};
				MVP_A_TRAVEL:   next_rdata = {20'h00000, travel};
				MVP_A_CLOSED:   next_rdata = {16'h0000, cal_closed};
				MVP_A_OPEN:     next_rdata = {16'h0000, cal_open};
				MVP_A_MV:       next_rdata = {16'h0000, mv};
				MVP_A_STATUS:   next_rdata = {25'h0000000, stat};
				MVP_A_POSITION: next_rdata = {{20{rep_pos[11]}}, rep_pos};
				MVP_A_IRQ_STAT: next_rdata = {29'h00000000, irq_stat};
				MVP_A_IRQ_MASK: next_rdata = {29'h00000000, irq_mask};
				MVP_A_RAW:      next_rdata = {16'h0000, raw_s2};
				default:        next_rdata = 32'h00000000;
			endcase
		end
		if (wr_stb && sel_i[1:0] == 2'b11) begin
			case (adr_i)
				// dead band clamped into its legal range
				MVP_A_DEADBAND: next_dead_band = (dat_i[15:0] < MVP_DB_MIN) ? MVP_DB_MIN
					: (dat_i[15:0] > MVP_DB_MAX) ? MVP_DB_MAX : dat_i[15:0];
				// travel time clamped into 5.0 to 300.0 s
				MVP_A_TRAVEL:   next_travel = (dat_i[15:0] < 16'(MVP_TR_MIN)) ? MVP_TR_MIN
					: (dat_i[15:0] > 16'(MVP_TR_MAX)) ? MVP_TR_MAX : dat_i[11:0];
				// raw calibration values may also be loaded directly
				MVP_A_CLOSED:   next_cal_closed = dat_i[15:0];
				MVP_A_OPEN:     next_cal_open = dat_i[15:0];
				MVP_A_MV:       next_mv = dat_i[15:0];
				default:        next_mv = mv;
			endcase
		end
		if (wr_stb && sel_i[0]) begin
			if (adr_i == MVP_A_IRQ_STAT)
				next_irq_stat = (irq_stat & ~dat_i[MVP_IRQ_W-1:0]) | irq_ev;
			if (adr_i == MVP_A_IRQ_MASK)
				next_irq_mask = dat_i[MVP_IRQ_W-1:0];
		end
		// mode write takes any of the four encodings
		if (wr_cal)
			next_mode = wmode;
		// capture the present reading; no span check applies
		if (wr_cal && wcmd == MVP_CAL_CLOSED)
			next_cal_closed = raw_s2;
		if (wr_cal && wcmd == MVP_CAL_OPEN)
			next_cal_open = raw_s2;
		// all values are stored together, only on success
		if (cal_store) begin
			next_cal_closed = tmp_closed;
			next_cal_open   = raw_s2;
			next_travel     = trav_meas + 12'h001 - MVP_STALL_TICKS;
		end
	end

	// All state registers but the input synchronizers; reset values are constants only
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tick_cnt <= 32'h0;            ack        <= 1'b0;
			rdata    <= 32'h0;            mode       <= MVP_FEEDBACK_MODE;
			dead_band <= MVP_DB_RST;      travel     <= MVP_TR_RST;
			cal_closed <= MVP_CLOSED_RST; cal_open   <= MVP_OPEN_RST;
			mv       <= 16'h0000;         irq_stat   <= '0;
			irq_mask <= '0;               cal_state  <= MVP_CS_IDLE;
			cal_cnt  <= 12'h000;          stall      <= 12'h000;
			trav_meas <= 12'h000;         snap       <= 16'h0000;
			tmp_closed <= 16'h0000;       fb_pct     <= 12'sh000;
			est_pos  <= 11'h000;          frac       <= 13'h0000;
			start_cnt <= 12'h000;         start_done <= 1'b0;
			open_q   <= 1'b0;             close_q    <= 1'b0;
			fault_q  <= 1'b0;
		end else begin
			tick_cnt <= next_tick_cnt;        ack        <= next_ack;
			rdata    <= next_rdata;           mode       <= next_mode;
			dead_band <= next_dead_band;      travel     <= next_travel;
			cal_closed <= next_cal_closed;    cal_open   <= next_cal_open;
			mv       <= next_mv;              irq_stat   <= next_irq_stat;
			irq_mask <= next_irq_mask;        cal_state  <= next_cal_state;
			cal_cnt  <= next_cal_cnt;         stall      <= next_stall;
			trav_meas <= next_trav_meas;      snap       <= next_snap;
			tmp_closed <= next_tmp_closed;    fb_pct     <= next_fb_pct;
			est_pos  <= next_est_pos;         frac       <= next_frac;
			start_cnt <= next_start_cnt;      start_done <= next_start_done;
			open_q   <= next_open;            close_q    <= next_close;
			fault_q  <= fault;
		end
	end

	assign ack_o         = ack;
	assign dat_o         = rdata;
	assign valve_open_o  = open_q;
	assign valve_close_o = close_q;
	assign irq_o         = |(irq_stat & irq_mask);

	//////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	drive_excl_a: assert property (!(open_q && close_q))
		else $error("open and close driven together");
	over_value_a: assert property (over && !estimating |-> rep_pos == 12'sh41a)
		else $error("over-range position not 105 percent");
	fallback_est_a: assert property (mode == MVP_FB_EST_MODE && fault |-> estimating && rep_pos == 12'(est_pos))
		else $error("fallback mode not estimating on fault");
	end_stop_a: assert property (estimating && !(mode == MVP_EST_TWO_MODE && !start_done)
		&& cal_state == MVP_CS_IDLE && mv <= 0 && !wr_cal |=> close_q && !open_q)
		else $error("estimation end stop close missing");
	dead_quiet_a: assert property (!estimating && cal_state == MVP_CS_IDLE && !wr_cal
		&& err <= off_th && err >= -off_th |=> !open_q && !close_q)
		else $error("output active inside dead band");
	hyst_hold_a: assert property (open_q && !estimating && cal_state == MVP_CS_IDLE && !wr_cal
		&& err > off_th |=> open_q)
		else $error("open released before hysteresis point");
	startup_close_a: assert property (mode == MVP_EST_TWO_MODE && !start_done && cal_state == MVP_CS_IDLE
		&& !wr_cal |=> close_q)
		else $error("startup close not driven");
	capture_a: assert property (wr_cal && wcmd == MVP_CAL_CLOSED && !cal_store |=> cal_closed == $past(raw_s2))
		else $error("closed capture not recorded");
	err_keeps_a: assert property (cal_state != MVP_CS_ERR ##1 cal_state == MVP_CS_ERR
		|-> $stable(cal_open) && $stable(cal_closed) && $stable(travel))
		else $error("values changed on calibration error");
	auto_refuse_a: assert property (wr_cal && wcmd == MVP_CAL_AUTO && wmode[1] && cal_state == MVP_CS_IDLE
		|=> cal_state == MVP_CS_IDLE)
		else $error("auto calibration started in estimation mode");
	bus_ack_a: assert property (cyc_i && stb_i && !ack |=> ack ##1 !ack)
		else $error("bus answer not one cycle");

	cal_ok_c: cover property (cal_done_ev);
	cal_fail_c: cover property (cal_err_ev);
	fallback_c: cover property (mode == MVP_FB_EST_MODE && !fault ##1 fault);
	est_step_c: cover property (estimating && open_q && est_pos != $past(est_pos));
endmodule

// *** bench/mvp_valve_model.sv ***
// Behavioural motorized valve with a potentiometer that follows the drive
module mvp_valve_model (
	input  wire logic   clk_i,
	input  wire logic   rst_i,
	input  wire logic   open_i,
	input  wire logic   close_i,
	output logic [15:0] raw_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] pos;
	// Slow slew keeps overshoot well inside the hysteresis band
	always_ff @(posedge clk_i) begin
		if (rst_i)
			pos <= 16'h0000;
		else if (open_i && pos < 16'hfffb)
			pos <= pos + 16'h0004;
		else if (close_i && pos > 16'h0003)
			pos <= pos - 16'h0004;
	end
	assign raw_o = pos;
endmodule

// *** bench/mvp_positioner_tb_top.sv ***
// Register-level tests of the valve positioner against the valve model
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin n_fail++; \
	$display("[FAIL] %0t got %h want %h", $time, a, e); end end
module mvp_positioner_tb_top import mvp_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk_i, rst_i, we, cyc, stb, ack, opn, cls, irq, nf, pf;
	logic [7:0]  adr;
	logic [31:0] wd, rd, q;
	logic [3:0]  sel;
	logic [15:0] raw;
	int          n_fail, n_compared, p;
	mvp_positioner #(.TICK_CYCLES(20)) dut (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr), .dat_i(wd), .sel_i(sel),
		.we_i(we), .cyc_i(cyc), .stb_i(stb), .dat_o(rd), .ack_o(ack), .fb_raw_i(raw), .fb_neg_fault_i(nf),
		.fb_pos_fault_i(pf), .valve_open_o(opn), .valve_close_o(cls), .irq_o(irq));
	mvp_valve_model valve (.clk_i(clk_i), .rst_i(rst_i), .open_i(opn), .close_i(cls), .raw_o(raw));
	// Clock at 50 ns
	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end
	// One classic Wishbone cycle; held until ack, then one idle cycle
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wd <= d; sel <= 4'hf;
		do begin @(posedge clk_i); n++; end while (ack !== 1'b1 && n < 100);
		if (n >= 100) n_fail++;
		q = rd;
		cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	task automatic close_out();
		if (n_fail == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Watchdog sized well beyond the longest settling waits
	initial begin
		idle(90000);
		n_fail++;
		close_out();
	end
	initial begin
		n_fail = 0; n_compared = 0;
		rst_i = 1'b1; we = 1'b0; cyc = 1'b0; stb = 1'b0; adr = 8'h00; wd = 32'h0; sel = 4'h0; nf = 1'b0; pf = 1'b0;
		idle(2);
		rst_i <= 1'b0;
		idle(1);
		// Reset values of settings and calibration
		wb(0, MVP_A_DEADBAND, 0); `CHK(q, 32'h00000064)
		wb(0, MVP_A_TRAVEL, 0); `CHK(q, 32'h0000012c)
		wb(0, MVP_A_OPEN, 0); `CHK(q, 32'h0000ffff)
		// Setting limits clamp out-of-range writes
		wb(1, MVP_A_DEADBAND, 0); wb(0, MVP_A_DEADBAND, 0); `CHK(q, 32'h00000005)
		wb(1, MVP_A_DEADBAND, 32'h7d0); wb(0, MVP_A_DEADBAND, 0); `CHK(q, 32'h000003e8)
		wb(1, MVP_A_TRAVEL, 32'hfff); wb(0, MVP_A_TRAVEL, 0); `CHK(q, 32'h00000bb8)
		wb(1, MVP_A_TRAVEL, 0); wb(0, MVP_A_TRAVEL, 0); `CHK(q, 32'h00000032)
		wb(1, MVP_A_DEADBAND, 32'h64); wb(0, 8'h3c, 0); `CHK(q, 32'h0)
		// Feedback loop settles inside the dead band around 50 %
		wb(1, MVP_A_MV, 32'h1f4); idle(12000);
		wb(0, MVP_A_POSITION, 0); p = int'(signed'(q[15:0]));
		`CHK(p >= 450 && p <= 550, 1'b1)
		`CHK({opn, cls}, 2'b00)
		// Capture closed records the raw reading; estimate mode one keeps the valve still meanwhile
		wb(1, MVP_A_CTRL, 32'h12); wb(0, MVP_A_CLOSED, 0); p = int'(q);
		wb(0, MVP_A_RAW, 0); `CHK(q, 32'(p))
		wb(0, MVP_A_CTRL, 0); `CHK(q[5:4], 2'b00)
		wb(1, MVP_A_CLOSED, 0); wb(1, MVP_A_CTRL, 0);
		// Wire faults substitute over and under range and raise the interrupt
		wb(1, MVP_A_IRQ_MASK, 32'h4); nf <= 1'b1; idle(80);
		wb(0, MVP_A_POSITION, 0); `CHK(q, 32'h0000041a)
		`CHK(irq, 1'b1)
		pf <= 1'b1; idle(80);
		wb(0, MVP_A_POSITION, 0); `CHK(q, 32'hffffffce)
		nf <= 1'b0; pf <= 1'b0; wb(1, MVP_A_IRQ_STAT, 32'h4); `CHK(irq, 1'b0)
		// Estimate mode one holds close at 0 and open at 100 despite a fault
		nf <= 1'b1; wb(1, MVP_A_CTRL, 32'h2); wb(1, MVP_A_MV, 0); idle(5); `CHK({opn, cls}, 2'b01)
		wb(1, MVP_A_MV, 32'h3e8); idle(5); `CHK({opn, cls}, 2'b10)
		wb(0, MVP_A_STATUS, 0); `CHK(q[2], 1'b1)
		// Automatic calibration refused in estimate-only mode
		wb(1, MVP_A_CTRL, 32'h32); wb(0, MVP_A_CTRL, 0); `CHK(q[5:4], 2'b00)
		// Fallback mode estimates on a fault and reports the estimate
		wb(1, MVP_A_CTRL, 32'h1); wb(0, MVP_A_STATUS, 0); `CHK(q[2], 1'b1)
		wb(0, MVP_A_POSITION, 0); `CHK(q <= 32'h3e8, 1'b1)
		// A burnout aborts automatic calibration and keeps the stored values
		wb(1, MVP_A_CTRL, 32'h30); idle(5); wb(0, MVP_A_STATUS, 0); `CHK(q[6:5], 2'b10)
		wb(0, MVP_A_CLOSED, 0); `CHK(q, 32'h0)
		// Estimate mode two closes for one stroke, then obeys the end stop
		nf <= 1'b0; idle(5); wb(1, MVP_A_CTRL, 32'h3); idle(5); `CHK({opn, cls}, 2'b01)
		idle(1100); `CHK({opn, cls}, 2'b10)
		// Full automatic calibration against the model's end stops
		wb(1, MVP_A_IRQ_STAT, 32'h3); wb(1, MVP_A_CTRL, 32'h30); wb(0, MVP_A_CTRL, 0); `CHK(q[5:4], 2'b11)
		idle(34000); wb(0, MVP_A_IRQ_STAT, 0); `CHK(q[1:0], 2'b01)
		wb(0, MVP_A_CLOSED, 0); `CHK(q <= 32'h3, 1'b1)
		wb(0, MVP_A_OPEN, 0); `CHK(q >= 32'hfffb, 1'b1)
		wb(0, MVP_A_TRAVEL, 0); `CHK(q >= 32'h32a && q <= 32'h33e, 1'b1)
		close_out();
	end
endmodule
